// ### master_dma_write_engine.sv
// Purpose: master-side DMA write engine of a ring I/O controller
// Assumes: one clock; ring and memory ports are same-clock logic
// Notes:   one transfer serviced at a time, up to two more queued
`timescale 1ns/1ps
`default_nettype none
`include "mdma_regs.svh"
module master_dma_write_engine #(
  parameter int DATA_W      = `WORD_W,
  parameter int FIFO_DEPTH  = `PAYLOAD_DEPTH,
  parameter int QUEUE_SLOTS = `QUEUE_SLOTS
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     ce,
  input  wire logic                     msg_valid,
  input  wire logic [`MSG_W-1:0]        msg_data,
  output logic                          msg_ack,
  output logic                          msg_nack,
  output logic                          mem_req_valid,
  input  wire logic                     mem_req_ready,
  output logic                          mem_req_vector,
  output logic [`WORD_W-1:0]            mem_req_pe,
  output logic [`WORD_W-1:0]            mem_req_offset,
  input  wire logic                     mem_rsp_valid,
  output logic                          mem_rsp_ready,
  input  wire logic [DATA_W-1:0]        mem_rsp_data,
  output logic                          ring_tx_valid,
  input  wire logic                     ring_tx_ready,
  output mdma_pkg::ring_kind_t          ring_tx_kind,
  output logic [`WORD_W-1:0]            ring_tx_addr,
  output logic [DATA_W-1:0]             ring_tx_data,
  input  wire logic                     ring_rx_valid,
  input  wire mdma_pkg::ring_kind_t     ring_rx_kind,
  input  wire logic                     ring_rx_refused,
  input  wire logic [`RATE_W-1:0]       ring_rx_rate,
  input  wire logic [`WORD_W-1:0]       ring_rx_addr,
  output logic                          report_valid,
  input  wire logic                     report_ready,
  output logic                          report_error,
  output logic [`WORD_W-1:0]            report_dest
);
  import mdma_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [CW-1:0] CRED_MAX = CW'(FIFO_DEPTH);

  // ==========================================================
  // state and transfer context
  state_t               state;
  logic [`WORD_W-1:0]   cmd;
  logic [`WORD_W-1:0]   stride;
  logic [`WORD_W-1:0]   mask;
  logic [`WORD_W-1:0]   init_addr;
  logic [`WORD_W-1:0]   fetch_addr;
  logic [`WORD_W-1:0]   slave_addr;
  logic [DATA_W-1:0]    init_pkt;
  logic [`LEN_W-1:0]    blocks_left;
  logic [`LEN_W-1:0]    fetch_left;
  logic [`RATE_W-1:0]   rate_limit;
  logic [`RATE_W-1:0]   outstanding;
  logic [CW-1:0]        credits;
  logic [`WORD_W-1:0]   req_addr;
  logic                 tx_fire;
  logic                 write_fire;
  logic                 fetch_fire;
  logic                 rx_init;
  logic                 rx_write;
  logic                 rx_finish;
  logic                 room;
  logic                 all_done;

  stream_if #(.W(`MSG_W)) head_s ();
  stream_if #(.W(DATA_W)) fill_s ();
  stream_if #(.W(DATA_W)) drain_s ();

  setup_queue #(
    .WIDTH (`MSG_W),
    .SLOTS (QUEUE_SLOTS)
  ) u_queue (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .msg_valid (msg_valid),
    .msg_data  (msg_data),
    .msg_ack   (msg_ack),
    .msg_nack  (msg_nack),
    .head      (head_s.producer)
  );

  payload_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_payload (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .fill  (fill_s.consumer),
    .drain (drain_s.producer)
  );

  // ==========================================================
  // handshakes
  assign room       = outstanding < rate_limit;
  assign tx_fire    = ring_tx_valid && ring_tx_ready;
  assign write_fire = tx_fire && state == st_xfer;
  assign fetch_fire = mem_req_valid && mem_req_ready;
  assign rx_init    = ce && ring_rx_valid && state == st_wait_reply &&
                      ring_rx_kind == write_block_initiate_reply;
  assign rx_write   = ce && ring_rx_valid && ring_rx_kind == write_data_reply &&
                      outstanding != '0;
  assign rx_finish  = ce && ring_rx_valid && state == st_wait_finish &&
                      ring_rx_kind == write_block_finish_reply;
  assign all_done   = blocks_left == '0 && outstanding == '0 && credits == '0;

  // stalled writes leave blocks in the buffer, which stops further fetches
  assign ring_tx_valid = ce && (state == st_send_init || state == st_send_finish ||
                         (state == st_xfer && drain_s.valid && room && blocks_left != '0));
  assign ring_tx_kind  = (state == st_send_init)   ? write_block_initiate_pkt :
                         (state == st_send_finish) ? write_block_finish_pkt : write_data_pkt;
  assign ring_tx_addr  = slave_addr;
  assign ring_tx_data  = (state == st_send_init) ? init_pkt : drain_s.data;
  assign drain_s.ready = write_fire;

  // source address split into processor number and offset by the mask
  assign req_addr       = (state == st_fetch_init) ? init_addr : fetch_addr;
  assign mem_req_valid  = ce && (state == st_fetch_init ||
                          (state == st_xfer && fetch_left != '0 && credits < CRED_MAX));
  assign mem_req_vector = state == st_xfer && cmd[`CMD_VECTOR_BIT];
  assign mem_req_pe     = req_addr & mask;
  assign mem_req_offset = req_addr & ~mask;
  assign fill_s.valid   = ce && state == st_xfer && mem_rsp_valid;
  assign fill_s.data    = mem_rsp_data;
  assign mem_rsp_ready  = (state == st_init_wait) || (state == st_xfer && fill_s.ready);

  assign report_valid = ce && state == st_report;
  assign head_s.ready = ce && state == st_report && report_ready;

  // ==========================================================
  // sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= st_idle;
    end else if (ce) begin
      case (state)
        st_idle:        if (head_s.valid) state <= st_fetch_init;
        st_fetch_init:  if (fetch_fire) state <= st_init_wait;
        st_init_wait:   if (mem_rsp_valid) state <= st_send_init;
        st_send_init:   if (tx_fire) state <= st_wait_reply;
        st_wait_reply:  if (rx_init) state <= ring_rx_refused ? st_report : st_xfer;
        st_xfer:        if (all_done) state <= st_send_finish;
        st_send_finish: if (tx_fire) state <= st_wait_finish;
        st_wait_finish: if (rx_finish) state <= st_report;
        st_report:      if (report_ready) state <= st_idle;
        default:        state <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // context from the setup message, and the initiate word fetched from memory
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd         <= `ZERO_WORD;
      stride      <= `ZERO_WORD;
      mask        <= `ZERO_WORD;
      init_addr   <= `ZERO_WORD;
      report_dest <= `ZERO_WORD;
    end else if (ce && state == st_idle && head_s.valid) begin
      cmd         <= head_s.data[`MSG_CMD_WORD*`WORD_W +: `WORD_W];
      stride      <= head_s.data[`MSG_STRIDE_WORD*`WORD_W +: `WORD_W];
      mask        <= head_s.data[`MSG_MASK_WORD*`WORD_W +: `WORD_W];
      init_addr   <= head_s.data[`MSG_BASE_WORD*`WORD_W +: `WORD_W];
      report_dest <= head_s.data[`MSG_DEST_WORD*`WORD_W +: `WORD_W];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      init_pkt <= '0;
    end else if (ce && state == st_init_wait && mem_rsp_valid) begin
      init_pkt <= mem_rsp_data;
    end
  end

  // ==========================================================
  // grant: rate and slave address, before any payload moves
  always_ff @(posedge clk) begin
    if (srst) begin
      rate_limit <= `RATE_FLOOR;
      slave_addr <= `ZERO_WORD;
    end else if (ce) begin
      if (rx_init && !ring_rx_refused) begin
        // a zero rate would stall forever, so at least one write may fly
        rate_limit <= (ring_rx_rate == '0) ? `RATE_FLOOR : ring_rx_rate;
        slave_addr <= ring_rx_addr;
      end else if (write_fire) begin
        slave_addr <= slave_addr + `SLAVE_ADDR_STEP;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      report_error <= 1'b0;
    end else if (ce) begin
      if (rx_init) report_error <= ring_rx_refused;
      else if (rx_finish) report_error <= 1'b0;
    end
  end

  // ==========================================================
  // block and fetch counters
  always_ff @(posedge clk) begin
    if (srst) begin
      blocks_left <= '0;
      fetch_left  <= '0;
      fetch_addr  <= `ZERO_WORD;
    end else if (ce) begin
      if (state == st_idle && head_s.valid) begin
        blocks_left <= head_s.data[`MSG_LEN_WORD*`WORD_W +: `LEN_W];
        fetch_left  <= head_s.data[`MSG_LEN_WORD*`WORD_W +: `LEN_W];
        fetch_addr  <= head_s.data[`MSG_START_WORD*`WORD_W +: `WORD_W];
      end else if (state == st_wait_reply && rx_init && ring_rx_refused) begin
        blocks_left <= '0;
        fetch_left  <= '0;
      end else if (state == st_xfer) begin
        if (write_fire) blocks_left <= blocks_left - 1'b1;
        if (fetch_fire) begin
          fetch_left <= fetch_left - 1'b1;
          fetch_addr <= fetch_addr + stride;
        end
      end
    end
  end

  // ==========================================================
  // outstanding writes and buffer credits
  always_ff @(posedge clk) begin
    if (srst) begin
      outstanding <= '0;
    end else if (ce) begin
      if (state == st_idle) outstanding <= '0;
      else outstanding <= `RATE_W'(outstanding + write_fire - rx_write);
    end
  end

  // credits count fetches issued but not yet sent, so the buffer never overflows
  always_ff @(posedge clk) begin
    if (srst) begin
      credits <= '0;
    end else if (ce) begin
      if (state == st_idle) credits <= '0;
      else credits <= CW'(credits + (fetch_fire && state == st_xfer) - write_fire);
    end
  end

  // ==========================================================
  // checks
  sequence grant_s;
    rx_init && !ring_rx_refused;
  endsequence

  sequence finished_s;
    ce && state == st_xfer && all_done;
  endsequence

  rate_bound_a: assert property (@(posedge clk) disable iff (srst)
    outstanding <= rate_limit) else $error("outstanding writes exceed rate");
  grant_taken_a: assert property (@(posedge clk) disable iff (srst)
    grant_s |=> state == st_xfer && slave_addr == $past(ring_rx_addr))
    else $error("grant address not taken");
  refuse_report_a: assert property (@(posedge clk) disable iff (srst)
    rx_init && ring_rx_refused |=> state == st_report && report_error)
    else $error("refusal not reported as error");
  write_counts_a: assert property (@(posedge clk) disable iff (srst)
    ce && write_fire |=> blocks_left == $past(blocks_left) - 1'b1)
    else $error("block counter did not step");
  stop_at_zero_a: assert property (@(posedge clk) disable iff (srst)
    blocks_left == '0 |-> !write_fire) else $error("write sent with zero blocks left");
  wait_replies_a: assert property (@(posedge clk) disable iff (srst)
    ce && state == st_xfer && blocks_left == '0 && outstanding != '0 |=> state == st_xfer)
    else $error("left transfer with writes outstanding");
  finish_sent_a: assert property (@(posedge clk) disable iff (srst)
    finished_s |=> state == st_send_finish ##0 ring_tx_kind == write_block_finish_pkt)
    else $error("finish packet not raised");
  init_after_fetch_a: assert property (@(posedge clk) disable iff (srst)
    ce && state == st_init_wait && mem_rsp_valid |=> ring_tx_kind == write_block_initiate_pkt
    && ring_tx_data == $past(mem_rsp_data)) else $error("initiate packet not forwarded");
  complete_report_a: assert property (@(posedge clk) disable iff (srst)
    rx_finish |=> state == st_report && !report_error)
    else $error("completion not reported");
endmodule
`default_nettype wire

// ### master_dma_write_engine_bench.sv
// Purpose: self-checking bench of the master DMA write engine
// Assumes: ce held high; far side is ring_slave_model
// Notes:   model follows the accepted message queue and every transfer
`timescale 1ns/1ps
`default_nettype none
module master_dma_write_engine_bench;
  import mdma_pkg::*;
  localparam logic [63:0] FILL = 64'h5a5a_0f0f_c3c3_3c3c;
  logic         clk, srst, ce, msg_valid, msg_ack, msg_nack, rr_rand = 1'b0;
  logic         mem_req_valid, mem_req_ready, mem_req_vector, mem_rsp_valid, mem_rsp_ready;
  logic         ring_tx_valid, ring_tx_ready, ring_rx_valid, ring_rx_refused;
  logic         report_valid, report_ready, report_error, took, exp_ack;
  logic [511:0] msg_data, m, q[$];
  logic [63:0]  mem_req_pe, mem_req_offset, mem_rsp_data, ring_tx_addr, ring_tx_data;
  logic [63:0]  ring_rx_addr, report_dest, base, a;
  logic [7:0]   ring_rx_rate;
  logic [23:0]  cnt;
  ring_kind_t   ring_tx_kind, ring_rx_kind;
  int           n_errors = 0, checks = 0, nf, nw, out, rate, ph;
  // reporting waits while a message is offered, so queue release and acceptance never coincide
  assign report_ready = rr_rand & ~msg_valid;
  master_dma_write_engine u_dut (.clk, .srst, .ce, .msg_valid, .msg_data, .msg_ack, .msg_nack,
    .mem_req_valid, .mem_req_ready, .mem_req_vector, .mem_req_pe, .mem_req_offset,
    .mem_rsp_valid, .mem_rsp_ready, .mem_rsp_data, .ring_tx_valid, .ring_tx_ready,
    .ring_tx_kind, .ring_tx_addr, .ring_tx_data, .ring_rx_valid, .ring_rx_kind,
    .ring_rx_refused, .ring_rx_rate, .ring_rx_addr, .report_valid, .report_ready,
    .report_error, .report_dest);
  ring_slave_model #(.FILL(FILL)) u_far (.clk, .srst, .mem_req_valid, .mem_req_ready,
    .mem_req_pe, .mem_req_offset, .mem_rsp_valid, .mem_rsp_ready, .mem_rsp_data,
    .ring_tx_valid, .ring_tx_ready, .ring_tx_kind, .ring_rx_valid, .ring_rx_kind,
    .ring_rx_refused, .ring_rx_rate, .ring_rx_addr);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [63:0] w(input logic [511:0] v, input int k);
    return v[64*k +: 64];
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // stimulus
  task automatic send(input int n);
    logic [511:0] v;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      for (int k = 0; k < 8; k++) v[64*k +: 64] = {$urandom, $urandom};
      v[63:0] = 64'($urandom_range(1));
      v[64 +: 64] = 64'($urandom_range(1, 4));
      v[128 +: 32] = 32'h0000_0000;
      // up to nine blocks, one more than the eight-word buffer holds, while the ring stalls
      v[192 +: 64] = 64'($urandom_range(9));
      msg_valid = 1'b1;
      msg_data = v;
    end
    @(negedge clk);
    msg_valid = 1'b0;
  endtask
  task automatic drain(input string name);
    for (int i = 0; i < 8000 && q.size() != 0; i++) @(negedge clk);
    if (q.size() != 0) n_errors++;
    $display("test %s done", name);
  endtask
  always @(negedge clk) rr_rand <= 1'($urandom_range(1));
  initial begin
    void'($urandom(43));
    srst = 1'b1;
    ce = 1'b1;
    msg_valid = 1'b0;
    msg_data = '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check(64'({mem_req_valid, ring_tx_valid, report_valid, msg_ack, msg_nack}), 64'h0);
    send(4);
    drain("burst_refusal");
    repeat (8) begin
      send(1 + $urandom_range(2));
      repeat ($urandom_range(80)) @(negedge clk);
    end
    drain("random_traffic");
    summarize();
  end
  initial begin
    #4_000_000;
    n_errors++;
    summarize();
  end
  // ==========================================================
  // reference model, sampled before this edge's updates land
  always @(posedge clk) begin
    if (srst) begin
      took = 1'b0;
      q.delete();
      {ph, nf, nw, out} = '0;
    end else begin
      m = (q.size() != 0) ? q[0] : '0;
      cnt = m[192 +: 24];
      if (took) begin
        check(64'(msg_ack), 64'(exp_ack));
        check(64'(msg_nack), 64'(!exp_ack));
      end
      took = msg_valid;
      if (msg_valid) begin
        exp_ack = q.size() < 3;
        if (exp_ack) q.push_back(msg_data);
      end
      if (mem_req_valid && mem_req_ready) begin
        a = (nf == 0) ? w(m, 4) : w(m, 5) + (nf - 1) * w(m, 1);
        check(mem_req_pe, a & w(m, 2));
        check(mem_req_offset, a & ~w(m, 2));
        if (nf != 0) check(64'(mem_req_vector), 64'(m[0]));
        if (nf != 0) check(64'(nf <= cnt), 64'h1);
        nf++;
      end
      if (ring_tx_valid && ring_tx_ready) begin
        if (ph == 0) begin
          check(64'(ring_tx_kind), 64'(write_block_initiate_pkt));
          check(ring_tx_data, w(m, 4) ^ FILL);
          ph = 1;
        end else if (ph == 2 && nw < cnt) begin
          check(64'(ring_tx_kind), 64'(write_data_pkt));
          check(ring_tx_addr, base + nw);
          check(ring_tx_data, (w(m, 5) + nw * w(m, 1)) ^ FILL);
          nw++;
          out++;
          check(64'(out <= rate), 64'h1);
        end else begin
          check(64'(ring_tx_kind), 64'(write_block_finish_pkt));
          check(64'(ph == 2 && out == 0), 64'h1);
          ph = 3;
        end
      end
      if (ring_rx_valid && ring_rx_kind == write_block_initiate_reply) begin
        ph = ring_rx_refused ? 4 : 2;
        base = ring_rx_addr;
        rate = (ring_rx_rate == 0) ? 1 : int'(ring_rx_rate);
      end
      if (ring_rx_valid && ring_rx_kind == write_data_reply) out--;
      if (ring_rx_valid && ring_rx_kind == write_block_finish_reply) ph = 5;
      if (report_valid && report_ready) begin
        check(64'(report_error), 64'(ph == 4));
        check(report_dest, w(m, 6));
        check(64'(ph >= 4), 64'h1);
        void'(q.pop_front());
        {ph, nf, nw, out} = '0;
      end
    end
  end
endmodule
`default_nettype wire

// ### mdma_pkg.sv
// Purpose: types shared by the master DMA write engine
// Assumes: nothing beyond the constants header
// Notes:   ring packet kinds and engine states
package mdma_pkg;

  // ==========================================================
  // ring packet kinds
  typedef enum logic [2:0] {
    write_block_initiate_pkt   = 3'b000,
    write_block_initiate_reply = 3'b001,
    write_data_pkt             = 3'b010,
    write_data_reply           = 3'b011,
    write_block_finish_pkt     = 3'b100,
    write_block_finish_reply   = 3'b101
  } ring_kind_t;

  // ==========================================================
  // engine states
  typedef enum logic [3:0] {
    st_idle        = 4'b0000,
    st_fetch_init  = 4'b0001,
    st_init_wait   = 4'b0010,
    st_send_init   = 4'b0011,
    st_wait_reply  = 4'b0100,
    st_xfer        = 4'b0101,
    st_send_finish = 4'b0110,
    st_wait_finish = 4'b0111,
    st_report      = 4'b1000
  } state_t;

endpackage

// ### mdma_regs.svh
// Purpose: constants of the master DMA write engine
// Assumes: 64-bit message words, eight words per setup message
// Notes:   definitions only
`ifndef MDMA_REGS_SVH
`define MDMA_REGS_SVH

// ==========================================================
// setup message layout (word index, 64 bits each)
`define MSG_WORDS        8
`define MSG_W            512
`define WORD_W           64
`define MSG_CMD_WORD     0
`define MSG_STRIDE_WORD  1
`define MSG_MASK_WORD    2
`define MSG_LEN_WORD     3
`define MSG_BASE_WORD    4
`define MSG_START_WORD   5
`define MSG_DEST_WORD    6
`define CMD_VECTOR_BIT   0

// ==========================================================
// sizing and reset values
`define QUEUE_SLOTS      3
`define PAYLOAD_DEPTH    8
`define RATE_W           8
`define LEN_W            24
`define SLAVE_ADDR_STEP  64'h0000_0000_0000_0001
`define RATE_FLOOR       8'h01
`define ZERO_WORD        64'h0000_0000_0000_0000

`endif

// ### payload_fifo.sv
// Purpose: payload buffer between remote fetch returns and write packets
// Assumes: push and pop in one clock domain
// Notes:   full and empty come straight from the count
`timescale 1ns/1ps
`default_nettype none
`include "mdma_regs.svh"
module payload_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = `PAYLOAD_DEPTH
) (
  input  wire logic   clk,
  input  wire logic   srst,
  input  wire logic   ce,
  stream_if.consumer  fill,
  stream_if.producer  drain
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign fill.ready  = ce && (count != FULL_CNT);
  assign drain.valid = ce && (count != '0);
  assign drain.data  = store[rd_idx];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_idx] <= fill.data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else if (ce) begin
      wr_idx <= push ? AW'(wr_idx + 1'b1) : wr_idx;
      rd_idx <= pop ? AW'(rd_idx + 1'b1) : rd_idx;
      count  <= (AW+1)'(count + push - pop);
    end
  end

  never_overfill_a: assert property (@(posedge clk) disable iff (srst)
    count <= FULL_CNT) else $error("payload buffer count beyond depth");
endmodule
`default_nettype wire

// ### ring_slave_model.sv
// Purpose: far side of the engine: slave ring client plus fetch memory
// Assumes: same clock as the engine; replies leave in arrival order
// Notes:   a fetched word is its address xor FILL; slave writes are not stored
`timescale 1ns/1ps
`default_nettype none
module ring_slave_model #(
  parameter logic [63:0] FILL = 64'h5a5a_0f0f_c3c3_3c3c
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 mem_req_valid,
  output logic                      mem_req_ready,
  input  wire logic [63:0]          mem_req_pe,
  input  wire logic [63:0]          mem_req_offset,
  output logic                      mem_rsp_valid,
  input  wire logic                 mem_rsp_ready,
  output logic [63:0]               mem_rsp_data,
  input  wire logic                 ring_tx_valid,
  output logic                      ring_tx_ready,
  input  wire mdma_pkg::ring_kind_t ring_tx_kind,
  output logic                      ring_rx_valid,
  output var mdma_pkg::ring_kind_t  ring_rx_kind,
  output logic                      ring_rx_refused,
  output logic [7:0]                ring_rx_rate,
  output logic [63:0]               ring_rx_addr
);
  import mdma_pkg::*;
  logic [63:0] words[$];
  ring_kind_t  replies[$];
  logic        shown = 1'b0;
  initial begin
    mem_req_ready = 1'b0;
    ring_tx_ready = 1'b0;
    mem_rsp_valid = 1'b0;
    mem_rsp_data = 64'h0000_0000_0000_0000;
    ring_rx_valid = 1'b0;
    ring_rx_kind = write_data_reply;
    ring_rx_refused = 1'b0;
    ring_rx_rate = 8'h00;
    ring_rx_addr = 64'h0000_0000_0000_0000;
  end
  // ==========================================================
  // take what the engine handed over at this edge
  always @(posedge clk) begin
    if (srst) begin
      words.delete();
      replies.delete();
      shown = 1'b0;
    end else begin
      if (mem_rsp_valid && mem_rsp_ready) begin
        void'(words.pop_front());
        shown = 1'b0;
      end
      if (mem_req_valid && mem_req_ready)
        words.push_back((mem_req_pe | mem_req_offset) ^ FILL);
      if (ring_tx_valid && ring_tx_ready) begin
        case (ring_tx_kind)
          write_block_initiate_pkt: replies.push_back(write_block_initiate_reply);
          write_data_pkt:           replies.push_back(write_data_reply);
          default:                  replies.push_back(write_block_finish_reply);
        endcase
      end
    end
  end
  // ==========================================================
  // answer off the sampling edge, with random stalls
  always @(negedge clk) begin
    mem_req_ready = $urandom_range(3) != 0;
    ring_tx_ready = $urandom_range(3) != 0;
    // an offered word may not be withdrawn before it is taken
    if (words.size() != 0 && (shown || $urandom_range(1) != 0)) begin
      mem_rsp_valid = 1'b1;
      mem_rsp_data = words[0];
      shown = 1'b1;
    end else begin
      mem_rsp_valid = 1'b0;
      mem_rsp_data = ~mem_rsp_data;
    end
    // one-cycle packets, never two in a row
    if (!ring_rx_valid && replies.size() != 0 && $urandom_range(2) == 0) begin
      ring_rx_valid = 1'b1;
      ring_rx_kind = replies.pop_front();
      ring_rx_refused = ring_rx_kind == write_block_initiate_reply && $urandom_range(3) == 0;
      ring_rx_rate = 8'($urandom_range(3));
      ring_rx_addr = {$urandom, $urandom};
    end else begin
      ring_rx_valid = 1'b0;
      ring_rx_refused = ~ring_rx_refused;
      ring_rx_rate = ~ring_rx_rate;
      ring_rx_addr = ~ring_rx_addr;
    end
  end
endmodule
`default_nettype wire

// ### setup_queue.sv
// Purpose: master write request queue with ack and nack replies
// Assumes: head entry stays until its transfer is reported
// Notes:   the serviced entry holds one of the slots
`timescale 1ns/1ps
`default_nettype none
`include "mdma_regs.svh"
module setup_queue #(
  parameter int WIDTH = `MSG_W,
  parameter int SLOTS = `QUEUE_SLOTS
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             msg_valid,
  input  wire logic [WIDTH-1:0] msg_data,
  output logic                  msg_ack,
  output logic                  msg_nack,
  stream_if.producer            head
);
  localparam int AW = $clog2(SLOTS);
  localparam logic [AW:0]   FULL_CNT = (AW+1)'(SLOTS);
  localparam logic [AW-1:0] LAST_IDX = AW'(SLOTS - 1);

  logic [WIDTH-1:0] slot [SLOTS];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             take;
  logic             pop;

  assign take       = ce && msg_valid && (count != FULL_CNT);
  assign pop        = head.valid && head.ready;
  assign head.valid = ce && (count != '0);
  assign head.data  = slot[rd_idx];

  always_ff @(posedge clk) begin
    if (take) begin
      slot[wr_idx] <= msg_data;
    end
  end

  // entries leave in arrival order
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else if (ce) begin
      if (take) wr_idx <= (wr_idx == LAST_IDX) ? '0 : AW'(wr_idx + 1'b1);
      if (pop) rd_idx <= (rd_idx == LAST_IDX) ? '0 : AW'(rd_idx + 1'b1);
      count <= (AW+1)'(count + take - pop);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      msg_ack  <= 1'b0;
      msg_nack <= 1'b0;
    end else if (ce) begin
      msg_ack  <= take;
      msg_nack <= msg_valid && !take;
    end
  end

  nack_when_full_a: assert property (@(posedge clk) disable iff (srst)
    ce && msg_valid && count == FULL_CNT |=> msg_nack && !msg_ack)
    else $error("full queue did not refuse");
  ack_when_room_a: assert property (@(posedge clk) disable iff (srst)
    ce && msg_valid && count < FULL_CNT |=> msg_ack && !msg_nack)
    else $error("queue with room did not acknowledge");
endmodule
`default_nettype wire

// ### stream_if.sv
// Purpose: valid/ready stream between the engine's own modules
// Assumes: one clock
// Notes:   producer drives valid and data
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 64);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface
`default_nettype wire
